// ==== ast_baud_gen.sv ====
// Baud tick generator: 8-bit divisor with a low or high speed prescale.
`timescale 1ns/10ps
`include "ast_regs.svh"
module ast_baud_gen #(
  parameter int DIV_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // Control
  input  wire logic                 run,
  input  wire logic [DIV_WIDTH-1:0] divisor,
  input  wire logic                 highSpeed,
  // Tick out
  output logic                      baudTick
);
  import ast_pkg::*;

  logic [3:0]           preCount;
  logic [DIV_WIDTH-1:0] divCount;
  wire  [3:0]           preTop  = highSpeed ? `AST_DIV_HIGH : `AST_DIV_LOW;
  wire                  preTick = (preCount == preTop);
  wire                  divDone = preTick && (divCount == divisor);

  // Rate is mclk / (prescale * (divisor + 1)).
  // Idle parks the prescaler one step on, because the registered tick lags divDone by a cycle;
  // without that the first bit after idle would run one cycle long.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      preCount <= 4'h0;
      divCount <= '0;
      baudTick <= 1'b0;
    end else if (!run) begin
      preCount <= 4'h1;
      divCount <= '0;
      baudTick <= 1'b0;
    end else begin
      preCount <= preTick ? 4'h0 : preCount + 4'h1;
      if (preTick) begin
        divCount <= divDone ? '0 : divCount + 1'b1;
      end
      baudTick <= divDone;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  property p_tick_single;
    @(posedge mclk) disable iff (reset) baudTick |=> !baudTick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("baud tick longer than one cycle");
endmodule : ast_baud_gen

// ==== ast_line_rx.sv ====
// Behavioural remote receiver that decodes frames seen on the serial line.
`timescale 1ns/10ps
module ast_line_rx #(
  parameter int CLK_NS = 5
) (
  // Clock and line
  input  wire logic        mclk,
  input  wire logic        line,
  // Character format
  input  wire logic [15:0] bitCycles,
  input  wire logic        nineBits,
  // Results
  output logic [8:0]       rxChar,
  output logic             frameErr,
  output int               frames,
  output int               lastPeriod
);
  // --------------------------------------------------------------------------
  // Frame decoder
  // --------------------------------------------------------------------------
  // Mid-bit sampling tolerates small skew; the start-to-start period catches a wrong rate.
  initial begin
    longint prevFall;
    prevFall = 0;
    rxChar = 9'h000;
    frameErr = 1'b0;
    frames = 0;
    lastPeriod = 0;
    forever begin
      @(posedge mclk);
      if (line === 1'b0) begin
        lastPeriod = int'(($time - prevFall) / CLK_NS);
        prevFall = $time;
        rxChar = 9'h000;
        repeat (bitCycles / 2) @(posedge mclk);
        if (line !== 1'b0) frameErr = 1'b1;
        for (int i = 0; i < (nineBits ? 9 : 8); i++) begin
          repeat (bitCycles) @(posedge mclk);
          rxChar[i] = line;
        end
        repeat (bitCycles) @(posedge mclk);
        if (line !== 1'b1) frameErr = 1'b1;
        frames++;
      end
    end
  end
endmodule : ast_line_rx

// ==== ast_pkg.sv ====
// Types shared by the serial transmitter files.
package ast_pkg;
  typedef enum logic [1:0] {
    AST_IDLE  = 2'b00,
    AST_START = 2'b01,
    AST_DATA  = 2'b10,
    AST_STOP  = 2'b11
  } ast_state_t;
endpackage : ast_pkg

// ==== ast_regs.svh ====
// Register offsets, field positions, reset values and timing constants of the serial transmitter.
`ifndef AST_REGS_SVH
`define AST_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define AST_OFF_TXCTL   4'h0
`define AST_OFF_RXCTL   4'h4
`define AST_OFF_BAUD    4'h8
`define AST_OFF_TXDATA  4'hC

// ----------------------------------------------------------------------------
// Transmit control and status fields, and the receive control port enable
// ----------------------------------------------------------------------------
`define AST_TXC_NINTH   0
`define AST_TXC_EMPTY   1
`define AST_TXC_HSPEED  2
`define AST_TXC_SYNC    4
`define AST_TXC_TX_ENABLE_BIT    5
`define AST_TXC_NINE    6
`define AST_TXC_IRQEN   8
`define AST_TXC_BUFEMP  9
`define AST_RXC_SERIAL_PORT_ENABLE    7

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define AST_TXC_RESET   8'h02
`define AST_BAUD_RESET  8'h00
`define AST_FLAG_DELAY  2'h2
`define AST_DIV_LOW     4'hF
`define AST_DIV_HIGH    4'h3
`define AST_RESP_OKAY   2'h0
`define AST_RESP_SLVERR 2'h2

`endif

// ==== ast_serial_tx.sv ====
// Asynchronous serial transmitter with holding register, shifter and AXI4-Lite registers.
`timescale 1ns/10ps
`include "ast_regs.svh"

// Summary of operation
// - Line idles at mark when not shifting.
// - Frame is start, 8/9 data, stop.
// - Each bit lasts one 8-bit-generator baud period.
// - Data bits leave least significant first.
// - No hardware parity; ninth bit carries it.
// - Runs only with enable, async, port on.
// - Port enable drives transmit pin as output.
// - Port enable forces receive pin to input.
// - Setting transmit enable sets buffer empty flag.
// - Holding write starts; idle shifter loads immediately.
// - Busy shifter: load after stop, start follows.
// - Flag high when enabled and holding empty.
// - Flag clears in second cycle after write.
// - Buffer empty flag is read only.
// - Interrupt enable gates request, not flag.
// - Shifter empty clears on load, no interrupt.
// - Nine-bit mode sends ninth bit last.
// - Transmit and receive share format and rate; only the nine-bit select goes out to the receiver.
module ast_serial_tx #(
  parameter int DATA_WIDTH = 8,
  parameter int DIV_WIDTH  = 8
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // AXI4-Lite write address and data
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins
  output logic             transmitPinOut,
  output logic             transmitPinOe,
  output logic             receivePinOe,
  // Shared setup to the receiver and interrupt request
  output logic             rxNineBitSelect,
  output logic             txIrqRequest
);
  import ast_pkg::*;

  // ----------------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------------
  logic                  txEnableBit;
  logic                  syncSelect;
  logic                  nineBitSelect;
  logic                  ninthDataBit;
  logic                  highSpeedBaudSelect;
  logic                  txIrqEnable;
  logic                  serialPortEnable;
  logic [DIV_WIDTH-1:0]  baudDivisorRegister;
  logic [DATA_WIDTH:0]   txHoldingRegister;
  logic                  holdFull;
  logic [1:0]            flagDelay;
  logic                  txBufferEmptyFlag;

  // Shifter state.
  ast_state_t            state;
  ast_state_t            next_state;
  logic [DATA_WIDTH:0]   txShiftRegister;
  logic [3:0]            bitCount;
  logic                  shifterEmptyStatus;
  logic                  baudTick;

  // ----------------------------------------------------------------------------
  // Bus handshake decode
  // ----------------------------------------------------------------------------
  logic       awHeld;
  logic       wHeld;
  logic [3:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  wire  awTake   = s_axi_awvalid && s_axi_awready;
  wire  wTake    = s_axi_wvalid && s_axi_wready;
  wire  writeGo  = awHeld && wHeld && !s_axi_bvalid;
  wire  arTake   = s_axi_arvalid && s_axi_arready;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == `AST_OFF_TXCTL) || (a == `AST_OFF_RXCTL) ||
             (a == `AST_OFF_BAUD)  || (a == `AST_OFF_TXDATA);
  endfunction : mapped

  wire wrCtl    = writeGo && wStrb[0] && (awAddr == `AST_OFF_TXCTL);
  wire wrCtlHi  = writeGo && wStrb[1] && (awAddr == `AST_OFF_TXCTL);
  wire wrRx     = writeGo && wStrb[0] && (awAddr == `AST_OFF_RXCTL);
  wire wrBaud   = writeGo && wStrb[0] && (awAddr == `AST_OFF_BAUD);
  wire wrData   = writeGo && wStrb[0] && (awAddr == `AST_OFF_TXDATA);

  // Asynchronous transmit runs only with all three control bits right.
  wire txActive = txEnableBit && !syncSelect && serialPortEnable;

  // A character moves over when the shifter is idle, or right as a stop ends.
  wire stopDone = (state == AST_STOP) && baudTick;
  wire shifterFree = (state == AST_IDLE) || stopDone;
  wire loadShift = txActive && holdFull && shifterFree;

  // Bus channel registers: address and data may arrive in either order.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 4'h0;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else begin
      if (awTake) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (writeGo) begin
        awHeld <= 1'b0;
      end
      if (wTake) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (writeGo) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Ready signals and the write response.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AST_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld && !awTake && !s_axi_awready;
      s_axi_wready  <= !wHeld && !wTake && !s_axi_wready;
      if (writeGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr) ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; the buffer empty and shifter empty bits come from live state.
  wire [31:0] txCtlView = {22'h0, txBufferEmptyFlag, txIrqEnable,
                           1'b0, nineBitSelect, txEnableBit, syncSelect, 1'b0,
                           highSpeedBaudSelect, shifterEmptyStatus, ninthDataBit};
  wire [31:0] rdView =
      (s_axi_araddr == `AST_OFF_TXCTL)  ? txCtlView :
      (s_axi_araddr == `AST_OFF_RXCTL)  ? {24'h0, serialPortEnable, 7'h00} :
      (s_axi_araddr == `AST_OFF_BAUD)   ? {24'h0, baudDivisorRegister} :
      (s_axi_araddr == `AST_OFF_TXDATA) ? {23'h0, txHoldingRegister} : 32'h0000_0000;

  // Read channel: address taken, data one cycle later.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AST_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !arTake && !s_axi_arready;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdView;
        s_axi_rresp  <= mapped(s_axi_araddr) ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Software control bits
  // ----------------------------------------------------------------------------
  // The two status bits in the control word are ignored on write.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ninthDataBit        <= 1'b0;
      highSpeedBaudSelect <= 1'b0;
      syncSelect          <= 1'b0;
      txEnableBit         <= 1'b0;
      nineBitSelect       <= 1'b0;
      txIrqEnable         <= 1'b0;
      serialPortEnable    <= 1'b0;
      baudDivisorRegister <= `AST_BAUD_RESET;
    end else begin
      if (wrCtl) begin
        ninthDataBit        <= wData[`AST_TXC_NINTH];
        highSpeedBaudSelect <= wData[`AST_TXC_HSPEED];
        syncSelect          <= wData[`AST_TXC_SYNC];
        txEnableBit         <= wData[`AST_TXC_TX_ENABLE_BIT];
        nineBitSelect       <= wData[`AST_TXC_NINE];
      end
      if (wrCtlHi) begin
        txIrqEnable <= wData[`AST_TXC_IRQEN];
      end
      if (wrRx) begin
        serialPortEnable <= wData[`AST_RXC_SERIAL_PORT_ENABLE];
      end
      if (wrBaud) begin
        baudDivisorRegister <= wData[DIV_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Holding register and buffer empty flag
  // ----------------------------------------------------------------------------
  // The ninth bit is captured with the low byte on the same write.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txHoldingRegister <= '0;
      holdFull          <= 1'b0;
      flagDelay         <= 2'h0;
    end else begin
      if (wrData) begin
        txHoldingRegister <= {ninthDataBit, wData[DATA_WIDTH-1:0]};
        holdFull          <= 1'b1;
        flagDelay         <= `AST_FLAG_DELAY;
      end else begin
        if (loadShift) begin
          holdFull <= 1'b0;
        end
        if (flagDelay != 2'h0) begin
          flagDelay <= flagDelay - 2'h1;
        end
      end
    end
  end

  // Flag lags a write by two cycles so a quick poll sees the old value;
  // software has no write path to it at all.
  wire flagTarget = txEnableBit && !(holdFull && !loadShift);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txBufferEmptyFlag <= 1'b0;
    end else if (flagDelay == 2'h0 || !txEnableBit) begin
      txBufferEmptyFlag <= flagTarget;
    end
  end

  // ----------------------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------------------
  wire [3:0] lastBit = nineBitSelect ? 4'(DATA_WIDTH) : 4'(DATA_WIDTH - 1);

  // Frame sequencer, one state step per baud tick.
  always_comb begin
    next_state = state;
    case (state)
      AST_IDLE:  if (loadShift) next_state = AST_START;
      AST_START: if (baudTick) next_state = AST_DATA;
      AST_DATA:  if (baudTick && bitCount == lastBit) next_state = AST_STOP;
      AST_STOP:  if (baudTick) next_state = loadShift ? AST_START : AST_IDLE;
      default:   next_state = AST_IDLE;
    endcase
    if (!txActive) next_state = AST_IDLE;
  end

  // Data leave from bit zero; no parity is computed here.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state              <= AST_IDLE;
      txShiftRegister    <= '0;
      bitCount           <= 4'h0;
      shifterEmptyStatus <= 1'b1;
    end else begin
      state <= next_state;
      if (loadShift) begin
        txShiftRegister    <= txHoldingRegister;
        bitCount           <= 4'h0;
        shifterEmptyStatus <= 1'b0;
      end else if (state == AST_DATA && baudTick) begin
        txShiftRegister <= txShiftRegister >> 1;
        bitCount        <= bitCount + 4'h1;
      end else if (next_state == AST_IDLE) begin
        shifterEmptyStatus <= 1'b1;
      end
    end
  end

  ast_baud_gen #(
    .DIV_WIDTH (DIV_WIDTH)
  ) u_baud (
    .mclk      (mclk),
    .reset     (reset),
    .run       (state != AST_IDLE),
    .divisor   (baudDivisorRegister),
    .highSpeed (highSpeedBaudSelect),
    .baudTick  (baudTick)
  );

  // ----------------------------------------------------------------------------
  // Pins and outputs
  // ----------------------------------------------------------------------------
  // Registered pin drive; idle is mark so a listener never sees a false start.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      transmitPinOut  <= 1'b1;
      transmitPinOe   <= 1'b0;
      receivePinOe    <= 1'b0;
      rxNineBitSelect <= 1'b0;
      txIrqRequest    <= 1'b0;
    end else begin
      case (next_state)
        AST_START: transmitPinOut <= 1'b0;
        AST_DATA:  transmitPinOut <= (state == AST_DATA && baudTick) ? txShiftRegister[1] :
                                     txShiftRegister[0];
        default:   transmitPinOut <= 1'b1;
      endcase
      transmitPinOe   <= serialPortEnable;
      receivePinOe    <= 1'b0;
      rxNineBitSelect <= nineBitSelect;
      txIrqRequest    <= txBufferEmptyFlag && txIrqEnable;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  property p_idle_mark;
    @(posedge mclk) disable iff (reset) (state == AST_IDLE) && !loadShift |=> transmitPinOut;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("line not at mark while idle");

  sequence s_start_entry;
    $rose(state == AST_START);
  endsequence
  property p_start_space;
    @(posedge mclk) disable iff (reset) s_start_entry |=> !transmitPinOut;
  endproperty
  a_start_space: assert property (p_start_space) else $error("start bit not at space");

  property p_load_clears_empty;
    @(posedge mclk) disable iff (reset) loadShift |=> !shifterEmptyStatus;
  endproperty
  a_load_clears_empty: assert property (p_load_clears_empty) else $error("shifter empty stuck");

  property p_inactive_idle;
    @(posedge mclk) disable iff (reset) !txActive |=> state == AST_IDLE;
  endproperty
  a_inactive_idle: assert property (p_inactive_idle) else $error("shifter ran while disabled");

  property p_flag_holds_after_write;
    @(posedge mclk) disable iff (reset) (wrData && txEnableBit) ##1 txEnableBit
      |-> $stable(txBufferEmptyFlag);
  endproperty
  a_flag_holds_after_write: assert property (p_flag_holds_after_write) else $error("flag moved early");

  property p_irq_gate;
    @(posedge mclk) disable iff (reset) !txIrqEnable ##1 !txIrqEnable |-> !txIrqRequest;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without enable");

  property p_oe_follows_port;
    @(posedge mclk) disable iff (reset) serialPortEnable |=> transmitPinOe && !receivePinOe;
  endproperty
  a_oe_follows_port: assert property (p_oe_follows_port) else $error("pin direction wrong");

  property p_ninth_capture;
    @(posedge mclk) disable iff (reset) wrData |=> txHoldingRegister[DATA_WIDTH] == $past(ninthDataBit);
  endproperty
  a_ninth_capture: assert property (p_ninth_capture) else $error("ninth bit not captured");

  property p_stop_to_start;
    @(posedge mclk) disable iff (reset) (stopDone && loadShift) |=> state == AST_START;
  endproperty
  a_stop_to_start: assert property (p_stop_to_start) else $error("gap after stop");
endmodule : ast_serial_tx

// ==== tb_async_serial_transmitter.sv ====
// Self-checking testbench of the serial transmitter with a line receiver model.
`timescale 1ns/10ps
`include "ast_regs.svh"
module tb_async_serial_transmitter;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic        mclk = 1'b0, reset = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        transmitPinOut, transmitPinOe, receivePinOe, rxNineBitSelect, txIrqRequest;
  logic [15:0] bitCycles = 16'h0008;
  logic        nineBits = 1'b0;
  logic [8:0]  rxChar;
  logic        frameErr, line;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          frames, lastPeriod, errCount = 0, nChecks = 0;

  // The line has a pull-up, so a released pin reads as mark.
  assign line = transmitPinOe ? transmitPinOut : 1'b1;
  always #2.5 mclk = ~mclk;

  ast_serial_tx ast_serial_tx_inst (.mclk(mclk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .transmitPinOut(transmitPinOut),
    .transmitPinOe(transmitPinOe), .receivePinOe(receivePinOe),
    .rxNineBitSelect(rxNineBitSelect), .txIrqRequest(txIrqRequest));

  ast_line_rx ast_line_rx_inst (.mclk(mclk), .line(line), .bitCycles(bitCycles),
    .nineBits(nineBits), .rxChar(rxChar), .frameErr(frameErr), .frames(frames),
    .lastPeriod(lastPeriod));

  // --------------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------------
  // Each bus task starts one edge on, so a release never meets a new request in one step.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Registered outputs that follow the write settle at this edge; look after it.
    #1;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_frames(input int n);
    while (frames < n) @(posedge mclk);
  endtask : wait_frames

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // --------------------------------------------------------------------------
  // Watchdog and test sequence
  // --------------------------------------------------------------------------
  // The whole sequence needs roughly a thousand cycles; this bound leaves ample slack.
  initial begin
    repeat (20000) @(posedge mclk);
    errCount++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check("idle line", line, 32'h1);
    check("tx oe reset", transmitPinOe, 32'h0);
    axi_read(`AST_OFF_TXCTL);
    check("ctl reset", rd, 32'h0000_0002);
    axi_read(4'h2);
    check("unmapped rd resp", rsp, 32'h2);
    check("unmapped rd data", rd, 32'h0);
    axi_write(4'h6, 32'hFFFF_FFFF);
    check("unmapped wr resp", rsp, 32'h2);
    axi_write(`AST_OFF_RXCTL, 32'h0000_0080);
    check("tx oe on", transmitPinOe, 32'h1);
    check("rx oe off", receivePinOe, 32'h0);
    axi_write(`AST_OFF_BAUD, 32'h0000_0001);
    axi_write(`AST_OFF_TXCTL, 32'h0000_0024);
    axi_read(`AST_OFF_TXCTL);
    check("flag on enable", rd, 32'h0000_0226);
    check("irq masked", txIrqRequest, 32'h0);
    axi_write(`AST_OFF_TXCTL, 32'h0000_0124);
    check("irq on", txIrqRequest, 32'h1);
    axi_write(`AST_OFF_TXDATA, 32'h0000_0055);
    axi_write(`AST_OFF_TXDATA, 32'h0000_00A3);
    // The flag only settles in the second cycle after the write, so poll a little later.
    repeat (2) @(posedge mclk);
    axi_read(`AST_OFF_TXCTL);
    check("queued status", rd, 32'h0000_0124);
    check("irq busy", txIrqRequest, 32'h0);
    axi_write(`AST_OFF_TXCTL, 32'h0000_0024);
    wait_frames(1);
    check("first char", rxChar, 32'h55);
    wait_frames(2);
    check("second char", rxChar, 32'hA3);
    check("no gap", lastPeriod >= 80 && lastPeriod <= 83, 32'h1);
    repeat (8) @(posedge mclk);
    axi_read(`AST_OFF_TXCTL);
    check("drained status", rd, 32'h0000_0226);
    nineBits <= 1'b1;
    axi_write(`AST_OFF_TXCTL, 32'h0000_0065);
    check("nine to rx", rxNineBitSelect, 32'h1);
    axi_write(`AST_OFF_TXDATA, 32'h0000_003C);
    wait_frames(3);
    check("nine bit char", rxChar, 32'h13C);
    repeat (8) @(posedge mclk);
    nineBits <= 1'b0;
    bitCycles <= 16'h0020;
    axi_write(`AST_OFF_TXCTL, 32'h0000_0020);
    axi_write(`AST_OFF_TXDATA, 32'h0000_00C1);
    wait_frames(4);
    check("low speed char", rxChar, 32'hC1);
    repeat (32) @(posedge mclk);
    axi_write(`AST_OFF_TXCTL, 32'h0000_0030);
    axi_write(`AST_OFF_TXDATA, 32'h0000_0099);
    repeat (400) @(posedge mclk);
    check("sync refused", frames, 32'h4);
    check("line idle", line, 32'h1);
    check("framing", frameErr, 32'h0);
    close_out();
  end
endmodule : tb_async_serial_transmitter
